// [verilog/hem_pkg.sv]
// constants shared by the host and controller mailbox block
package hem_pkg;
    // host access port offsets, also the controller runtime offsets
    localparam logic host_off_index = 1'b0;
    localparam logic host_off_data = 1'b1;
    // indexed register map
    localparam logic [7:0] idx_h2c_mbox = 8'h00;
    localparam logic [7:0] idx_c2h_mbox = 8'h01;
    localparam logic [7:0] idx_smi_src = 8'h02;
    localparam logic [7:0] idx_smi_mask = 8'h03;
    localparam logic [7:0] idx_mbox_first = 8'h10;
    localparam logic [7:0] idx_mbox_last = 8'h2f;
    // controller byte offsets of the 32-bit words
    localparam logic [9:0] ec_off_port = 10'h000;
    localparam logic [9:0] ec_off_h2c = 10'h100;
    localparam logic [9:0] ec_off_c2h = 10'h104;
    localparam logic [9:0] ec_off_src = 10'h108;
    localparam logic [9:0] ec_off_mask = 10'h10c;
    localparam logic [9:0] ec_off_mbox = 10'h110;
    localparam logic [9:0] ec_off_mbox_end = 10'h12c;
    // field layout of smi source and mask
    localparam int bit_controller_wrote_flag = 0;
    localparam logic [7:0] swi_field = 8'hfe;
    // special mailbox values
    localparam logic [7:0] mbox_done = 8'hff;
    localparam logic [7:0] byte_reset = 8'h00;
    // mailbox byte count and clock
    localparam int mbox_bytes = 32;
    localparam int clk_hz = 100_000_000;
endpackage

// [verilog/hem_mailbox.sv]
// host and embedded controller mailbox with index/data host port
//
// Notes on behaviour
// - thirty-six byte registers reached by index
// - thirty-two mailbox bytes, both sides read/write
// - four signalling registers: two mailboxes, smi regs
// - host port: index and data bytes
// - index first, then data hits indexed register
// - controller may also use index/data port
// - serial irq when wrote flag and enable
// - smi when any swi bit and enable
// - smi also from wrote flag and enable
// - smi to any selected frame, and also to the pin when selected
// - smi gives active-low frame and pin level
// - host mailbox write raises controller interrupt
// - controller writing ffh clears host mailbox
// - host writing ffh clears controller mailbox
// - controller mailbox write can raise host smi
// - system reset clears all block state
// - port registers reset while rail absent
// - all logic on the single block clock
// - block idles to low power by itself
// - index at offset 0, data at 1
// - index map 00-03 and 10h-2fh
// - controller read of the h2c mailbox word clears mailbox interrupt
`timescale 1ns/1ns
module hem_mailbox import hem_pkg::*; #(
    parameter int frames = 16
) (
    // clock and resets
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic main_rail_good,
    // host i/o port
    input wire logic host_addr,
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic [7:0] host_wdata,
    output logic [7:0] host_rdata_r,
    // controller register port
    input wire logic [9:0] ec_addr,
    input wire logic controller_wrote_flag,
    input wire logic ec_rd,
    input wire logic [3:0] ec_be,
    input wire logic [31:0] ec_wdata,
    output logic [31:0] ec_rdata_r,
    // routing of the smi event
    input wire logic [3:0] smi_frame_sel,
    input wire logic alert_pin_select,
    // events and pins
    output logic controller_mailbox_irq_r,
    output logic host_serial_irq_source_r,
    output logic host_smi_source_r,
    output logic [frames-1:0] smi_frame_n_r,
    output logic host_alert_pin_out_r,
    output logic host_alert_pin_oe_r,
    output logic low_power_r
);

    ////////////////////////////////////////////////////////////////////
    // storage
    logic [7:0] index_r, h2c_r, c2h_r, src_r, mask_r;
    logic [7:0] mbox_r [mbox_bytes];
    // true when an index selects a defined register
    function automatic logic idx_valid(input logic [7:0] idx);
        return idx <= idx_smi_mask ||
               (idx >= idx_mbox_first && idx <= idx_mbox_last);
    endfunction

    // read value of an indexed register, zero if undefined
    function automatic logic [7:0] idx_read(input logic [7:0] idx);
        logic [7:0] v;
        v = byte_reset;
        case (idx)
            idx_h2c_mbox: v = h2c_r;
            idx_c2h_mbox: v = c2h_r;
            idx_smi_src: v = src_r;
            idx_smi_mask: v = mask_r;
            default: begin
                if (idx_valid(idx)) begin
                    v = mbox_r[5'(idx - idx_mbox_first)];
                end
            end
        endcase
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // host port merge; host wins over a same-cycle controller index/data port access
    logic ec_port, idx_wr, pw, ec_dir, pw_mbox;
    logic [7:0] idx_wdata, pw_data;
    logic [9:0] ec_word;
    logic [4:0] pw_slot;
    always_comb begin
        ec_word = {ec_addr[9:2], 2'b00};
        ec_port = ec_word == ec_off_port;
        ec_dir = controller_wrote_flag && !ec_port;
        idx_wr = (host_wr && host_addr == host_off_index) ||
                 (controller_wrote_flag && ec_port && ec_be[0]);
        idx_wdata = (host_wr && host_addr == host_off_index) ?
                    host_wdata : ec_wdata[7:0];
        pw = (host_wr && host_addr == host_off_data) ||
             (controller_wrote_flag && ec_port && ec_be[1]);
        pw_data = (host_wr && host_addr == host_off_data) ?
                  host_wdata : ec_wdata[15:8];
        pw_slot = 5'(index_r - idx_mbox_first);
        pw_mbox = pw && index_r >= idx_mbox_first &&
                  index_r <= idx_mbox_last;
    end

    // index byte; reset by either reset or a missing rail
    always_ff @(posedge clk) begin
        if (sys_rst || !main_rail_good) begin
            index_r <= byte_reset;
        end else if (idx_wr) begin
            index_r <= idx_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // the thirty-two shared mailbox bytes
    genvar g;
    generate
        for (g = 0; g < mbox_bytes; g++) begin : g_mbox
            logic ec_hit;
            assign ec_hit = ec_dir && ec_be[g % 4] &&
                ec_word == ec_off_mbox + 10'(4 * (g / 4));
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    mbox_r[g] <= byte_reset;
                end else if (pw_mbox && pw_slot == 5'(g)) begin
                    mbox_r[g] <= pw_data;
                end else if (ec_hit) begin
                    mbox_r[g] <= ec_wdata[8 * (g % 4) +: 8];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // command mailboxes; simultaneous writers are software's problem
    logic ec_h2c_wr, ec_c2h_wr, ec_h2c_rd, pw_h2c, pw_c2h;
    always_comb begin
        ec_h2c_wr = ec_dir && ec_be[0] && ec_word == ec_off_h2c;
        ec_c2h_wr = ec_dir && ec_be[0] && ec_word == ec_off_c2h;
        ec_h2c_rd = ec_rd && ec_word == ec_off_h2c;
        pw_h2c = pw && index_r == idx_h2c_mbox;
        pw_c2h = pw && index_r == idx_c2h_mbox;
    end

    // host write stores; controller clears the bits it writes as one
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            h2c_r <= byte_reset;
        end else if (pw_h2c) begin
            h2c_r <= pw_data;
        end else if (ec_h2c_wr) begin
            h2c_r <= h2c_r & ~ec_wdata[7:0]; // ffh gives 00h
        end
    end

    // controller write stores; host ffh signals done
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            c2h_r <= byte_reset;
        end else if (ec_c2h_wr) begin
            c2h_r <= ec_wdata[7:0];
        end else if (pw_c2h) begin
            c2h_r <= (pw_data == mbox_done) ? byte_reset : pw_data;
        end
    end

    // mailbox interrupt; a new host write beats the clearing read
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            controller_mailbox_irq_r <= 1'b0;
        end else if (pw_h2c) begin
            controller_mailbox_irq_r <= 1'b1;
        end else if (ec_h2c_rd) begin
            controller_mailbox_irq_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // smi source and mask; hardware set wins over host clear
    logic [7:0] src_set, src_clr, src_nxt;
    always_comb begin
        src_set = byte_reset;
        src_set[bit_controller_wrote_flag] = ec_c2h_wr;
        if (ec_dir && ec_be[0] && ec_word == ec_off_src) begin
            src_set = src_set | (ec_wdata[7:0] & swi_field);
        end
        src_clr = (pw && index_r == idx_smi_src) ? pw_data : byte_reset;
        src_nxt = (src_r & ~src_clr) | src_set;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            src_r <= byte_reset;
        end else begin
            src_r <= src_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mask_r <= byte_reset;
        end else if (pw && index_r == idx_smi_mask) begin
            mask_r <= pw_data;
        end else if (ec_dir && ec_be[0] && ec_word == ec_off_mask) begin
            mask_r <= ec_wdata[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // host events and their routing
    logic wr_event, smi_event;
    logic [3:0] smi_frame_sel_d;
    always_comb begin
        wr_event = src_r[bit_controller_wrote_flag] && mask_r[bit_controller_wrote_flag];
        smi_event = |(src_r & mask_r);
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            host_serial_irq_source_r <= 1'b0;
            host_smi_source_r <= 1'b0;
            host_alert_pin_oe_r <= 1'b0;
            smi_frame_n_r <= '1;
            host_alert_pin_out_r <= 1'b0;
        end else begin
            host_alert_pin_out_r <= 1'b0;
            host_serial_irq_source_r <= wr_event;
            host_smi_source_r <= smi_event;
            // open drain: only ever drives low
            host_alert_pin_oe_r <= smi_event && alert_pin_select;
            for (int f = 0; f < frames; f++) begin
                smi_frame_n_r[f] <= !(smi_event &&
                    smi_frame_sel == 4'(f));
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read answers, registered one cycle after the strobe
    always_ff @(posedge clk) begin
        if (sys_rst || !main_rail_good) begin
            host_rdata_r <= byte_reset;
        end else if (host_rd) begin
            host_rdata_r <= (host_addr == host_off_index) ?
                            index_r : idx_read(index_r);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ec_rdata_r <= '0;
        end else if (ec_rd) begin
            ec_rdata_r <= '0; // unmapped words read zero
            if (ec_port) begin
                ec_rdata_r <= {16'h0000, idx_read(index_r), index_r};
            end else if (ec_word >= ec_off_h2c &&
                         ec_word <= ec_off_mask) begin
                ec_rdata_r <= {24'h000000,
                    idx_read(8'(ec_word[3:2]))};
            end else if (ec_word >= ec_off_mbox &&
                         ec_word <= ec_off_mbox_end) begin
                for (int b = 0; b < 4; b++) begin
                    ec_rdata_r[8 * b +: 8] <= mbox_r[5'(
                        {ec_word[4:2] - 3'h4, 2'(b)})];
                end
            end
        end
    end

    // idle whenever no access is in flight; no software needed
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            low_power_r <= 1'b0;
        end else begin
            low_power_r <= !(host_wr || host_rd || controller_wrote_flag || ec_rd);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_index_write;
        host_wr && host_addr == host_off_index &&
        host_wdata == idx_mbox_first;
    endsequence
    sequence s_data_write;
        host_wr && host_addr == host_off_data;
    endsequence
    a_route_data: assert property (
        s_index_write ##1 !idx_wr ##1 s_data_write |=>
        mbox_r[0] == $past(host_wdata))
        else $error("indexed data write missed mailbox byte 0");
    a_irq_raise: assert property (pw_h2c |=> controller_mailbox_irq_r)
        else $error("host mailbox write did not raise interrupt");
    a_irq_clear: assert property (
        ec_h2c_rd && !pw_h2c |=> !controller_mailbox_irq_r)
        else $error("controller read did not clear interrupt");
    a_h2c_done: assert property (
        ec_h2c_wr && !pw_h2c && ec_wdata[7:0] == mbox_done |=>
        h2c_r == byte_reset)
        else $error("ffh from controller did not clear mailbox");
    a_c2h_done: assert property (
        pw_c2h && !ec_c2h_wr && pw_data == mbox_done |=>
        c2h_r == byte_reset)
        else $error("ffh from host did not clear mailbox");
    a_serirq_src: assert property (
        wr_event |=> host_serial_irq_source_r)
        else $error("serial irq source missing");
    a_smi_wr: assert property (
        ec_c2h_wr && mask_r[bit_controller_wrote_flag] && !ec_h2c_wr ##1 mask_r[bit_controller_wrote_flag]
        |=> host_smi_source_r)
        else $error("controller mailbox write gave no smi");
    a_smi_frame: assert property (
        host_smi_source_r |-> smi_frame_n_r[smi_frame_sel_d] == 1'b0)
        else $error("smi frame not driven low");
    a_unmapped_zero: assert property (
        host_rd && host_addr == host_off_data && !idx_valid(index_r)
        |=> host_rdata_r == byte_reset)
        else $error("undefined index read not zero");
    a_rail_reset: assert property (
        !main_rail_good |=> index_r == byte_reset)
        else $error("index survived missing rail");
    // frame select as used by the registered frame outputs
    always_ff @(posedge clk) begin
        smi_frame_sel_d <= smi_frame_sel;
    end

endmodule

// [verification/hem_host_model.sv]
// host processor model driving the mailbox index and data port
`timescale 1ns/1ns
module hem_host_model import hem_pkg::*; (
    // clock
    input wire logic clk,
    // host i/o port
    output logic host_addr,
    output logic host_wr,
    output logic host_rd,
    output logic [7:0] host_wdata,
    input wire logic [7:0] host_rdata_r
);
    // idle port at time zero
    initial begin
        host_addr = 1'b0;
        host_wr = 1'b0;
        host_rd = 1'b0;
        host_wdata = 8'h00;
    end
    // one strobe cycle, launched and released at falling edges
    task automatic cyc(input logic a, input logic w, input logic [7:0] d);
        @(negedge clk);
        host_addr = a;
        host_wr = w;
        host_rd = ~w;
        host_wdata = d;
        @(negedge clk);
        host_wr = 1'b0;
        host_rd = 1'b0;
        host_wdata = ~d; // released bus must not keep the old byte
    endtask
    // index goes first, one access at a time
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        cyc(host_off_index, 1'b1, idx);
        cyc(host_off_data, 1'b1, d);
    endtask
    // registered answer is taken a cycle after the strobe
    task automatic rd(input logic [7:0] idx, output logic [7:0] d);
        cyc(host_off_index, 1'b1, idx);
        cyc(host_off_data, 1'b0, 8'h00);
        @(negedge clk);
        d = host_rdata_r;
    endtask
endmodule

// [verification/testbench.sv]
// self-checking bench for the host and controller mailbox
`timescale 1ns/1ns
module testbench import hem_pkg::*; ;
    logic clk, sys_rst, main_rail_good, host_addr, host_wr, host_rd;
    logic [7:0] host_wdata, host_rdata_r, b, m;
    logic [9:0] ec_addr;
    logic controller_wrote_flag, ec_rd, alert_pin_select, irq, ser, smi, pin, oe, lp;
    logic [3:0] ec_be, smi_frame_sel;
    logic [31:0] ec_wdata, ec_rdata_r, w;
    logic [15:0] frm;
    logic [7:0] mb [32];
    int seed, errors, tests_run, cycles, i, k;
    hem_mailbox uut (.clk(clk), .sys_rst(sys_rst),
        .main_rail_good(main_rail_good), .host_addr(host_addr),
        .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata),
        .host_rdata_r(host_rdata_r), .ec_addr(ec_addr), .controller_wrote_flag(controller_wrote_flag),
        .ec_rd(ec_rd), .ec_be(ec_be), .ec_wdata(ec_wdata),
        .ec_rdata_r(ec_rdata_r), .smi_frame_sel(smi_frame_sel),
        .alert_pin_select(alert_pin_select),
        .controller_mailbox_irq_r(irq), .host_serial_irq_source_r(ser),
        .host_smi_source_r(smi), .smi_frame_n_r(frm),
        .host_alert_pin_out_r(pin), .host_alert_pin_oe_r(oe),
        .low_power_r(lp));
    hem_host_model host (.clk(clk), .host_addr(host_addr),
        .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata),
        .host_rdata_r(host_rdata_r));
    ////////////////////////////////////////////////////////////////////////
    // 100 MHz clock
    initial clk = 1'b0;
    always #5 clk = ~clk;
    // hang guard, far above the length of the sequence
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            conclude();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // expected frame pattern: selected frame pulled low while smi stands
    function automatic logic [15:0] exp_frm(input logic on, input logic [3:0] s);
        exp_frm = on ? ~(16'h0001 << s) : 16'hffff;
    endfunction
    function automatic logic exp_smi(input logic [7:0] s, input logic [7:0] k);
        exp_smi = |(s & k);
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // controller strobe cycle, same discipline as the host side
    task automatic ecyc(input logic [9:0] a, input logic wr,
                        input logic [3:0] be, input logic [31:0] d);
        @(negedge clk);
        ec_addr = a;
        controller_wrote_flag = wr;
        ec_rd = ~wr;
        ec_be = be;
        ec_wdata = d;
        @(negedge clk);
        controller_wrote_flag = 1'b0;
        ec_rd = 1'b0;
        ec_wdata = ~d;
    endtask
    task automatic erd(input logic [9:0] a, output logic [31:0] d);
        ecyc(a, 1'b0, 4'h0, 32'h0);
        @(negedge clk);
        d = ec_rdata_r;
    endtask
    task automatic done(input string name);
        $display("test %s finished", name);
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        seed = 50204;
        {ec_addr, controller_wrote_flag, ec_rd, ec_be, ec_wdata} = '0;
        smi_frame_sel = 4'h0;
        alert_pin_select = 1'b0;
        main_rail_good = 1'b1;
        sys_rst = 1'b1;
        repeat (16) @(negedge clk);
        sys_rst = 1'b0;
        chk({irq, ser, smi, oe, frm}, {4'h0, 16'hffff});
        done("reset");
        for (i = 0; i < 32; i++) begin
            mb[i] = 8'($random(seed));
            host.wr(idx_mbox_first + 8'(i), mb[i]);
        end
        for (i = 0; i < 8; i++) begin
            erd(ec_off_mbox + 10'(4 * i), w);
            chk(w, {mb[4*i+3], mb[4*i+2], mb[4*i+1], mb[4*i]});
        end
        w = $random(seed);
        ec_be = 4'($random(seed));
        m = {4'h0, ec_be};
        ecyc(ec_off_mbox_end, 1'b1, m[3:0], w);
        for (k = 0; k < 4; k++) begin
            if (m[k]) mb[28+k] = w[8*k+:8];
            host.rd(idx_mbox_last - 8'(3 - k), b);
            chk(b, mb[28+k]);
        end
        done("mailbox bytes");
        // reserved indexes, including either side of the byte range
        for (k = 0; k < 4; k++) begin
            m = (k == 0) ? 8'h04 : (k == 1) ? 8'h0f : (k == 2) ? 8'h30 : 8'hff;
            host.wr(m, 8'h5a);
            host.rd(m, b);
            chk(b, 8'h00);
        end
        done("undefined index");
        b = {1'b0, 7'($random(seed))} | 8'h01;
        host.wr(idx_h2c_mbox, b);
        repeat (2) @(negedge clk);
        chk(irq, 1'b1);
        erd(ec_off_h2c, w);
        chk(w[7:0], b);
        repeat (2) @(negedge clk);
        chk(irq, 1'b0);
        ecyc(ec_off_h2c, 1'b1, 4'h1, {24'h0, mbox_done});
        host.rd(idx_h2c_mbox, b);
        chk(b, 8'h00);
        done("host to controller");
        for (i = 0; i < 2; i++) begin
            smi_frame_sel = 4'($random(seed));
            alert_pin_select = i[0];
            host.wr(idx_smi_mask, 8'h01);
            ecyc(ec_off_c2h, 1'b1, 4'h1, {24'h0, 8'h3c});
            repeat (3) @(negedge clk);
            chk({ser, smi}, 2'b11);
            chk(frm, exp_frm(1'b1, smi_frame_sel));
            chk({pin, oe}, {1'b0, i[0]});
            host.wr(idx_c2h_mbox, mbox_done);
            host.rd(idx_c2h_mbox, b);
            chk(b, 8'h00);
            host.wr(idx_smi_src, 8'h01);
            repeat (3) @(negedge clk);
            chk({smi, oe, frm}, {2'b00, 16'hffff});
        end
        done("controller to host");
        for (i = 1; i < 8; i++) begin
            m = 8'($random(seed));
            host.wr(idx_smi_mask, m);
            ecyc(ec_off_src, 1'b1, 4'h1, 32'h1 << i);
            repeat (3) @(negedge clk);
            chk({ser, smi}, {1'b0, exp_smi(8'h01 << i, m)});
            host.wr(idx_smi_src, 8'h01 << i);
        end
        done("software sources");
        ecyc(ec_off_port, 1'b1, 4'h1, {24'h0, idx_mbox_first});
        ecyc(ec_off_port, 1'b1, 4'h2, 32'h7700);
        host.rd(idx_mbox_first, b);
        chk(b, 8'h77);
        repeat (3) @(negedge clk);
        chk(lp, 1'b1);
        main_rail_good = 1'b0;
        repeat (2) @(negedge clk);
        chk(host_rdata_r, 8'h00);
        main_rail_good = 1'b1;
        // index held 10h before the rail dropped; it must read back zero
        host.cyc(host_off_index, 1'b0, 8'h00);
        @(negedge clk);
        chk(host_rdata_r, 8'h00);
        done("port and rail");
        host.wr(idx_h2c_mbox, 8'h42);
        sys_rst = 1'b1;
        @(negedge clk);
        sys_rst = 1'b0;
        host.rd(idx_mbox_first, b);
        chk({irq, b}, 9'h000);
        done("mid-run reset");
        conclude();
    end
endmodule
